// [flag_pkg.sv]
// constants for the processor status-word interrupt gating block
package flag_pkg;
   localparam int PRIO_W       = 3;
   localparam int WORD_W       = 11;
   // status-word bit positions
   localparam int POS_CARRY    = 0;
   localparam int POS_DEBUG    = 1;
   localparam int POS_ZERO     = 2;
   localparam int POS_SIGN     = 3;
   localparam int POS_BANK     = 4;
   localparam int POS_OVF      = 5;
   localparam int POS_IEN      = 6;
   localparam int POS_STK      = 7;
   localparam int POS_RSVD     = 8;
   localparam int POS_PRIO     = 12;
   localparam int SWI_LAST_LOW = 31;
   // register map, byte addresses
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_REQ    = 4'h4;
   localparam logic [3:0] ADDR_CTRL   = 4'h8;
   // reset values
   localparam logic [2:0] PRIO_RST = 3'h0;
   localparam logic       IEN_RST  = 1'b0;
   localparam logic       STK_RST  = 1'b0;
   localparam logic       OVF_RST  = 1'b0;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// [prio_gate.sv]
// request eligibility check against interrupt enable and priority level
`timescale 1ns/1ps
module prio_gate #(
   parameter int PW = 3
) (
   // request
   input  wire logic          req_valid,
   input  wire logic          req_nmi,
   input  wire logic [PW-1:0] req_prio,
   // current state
   input  wire logic          ien,
   input  wire logic [PW-1:0] cpu_prio_level,
   // result
   output logic               accept
);
   logic above;
   always_comb begin
      above = (req_prio > cpu_prio_level);
      // non-maskable requests skip both gates
      accept = req_valid & (req_nmi | (ien & above));
   end
endmodule // prio_gate

// [cpu_flag_interrupt_gating.sv]
// interrupt-related status-word bits, acceptance and acknowledge updates
`timescale 1ns/1ps
module cpu_flag_interrupt_gating #(
   parameter int PW = flag_pkg::PRIO_W
) (
   // clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst,
   // execution datapath
   input  wire logic          alu_update,
   input  wire logic          alu_overflow,
   input  wire logic          swi_exec,
   input  wire logic [5:0]    swi_num,
   // hardware request source
   input  wire logic          hw_req,
   input  wire logic          hw_req_nmi,
   input  wire logic [PW-1:0] hw_req_prio,
   output logic               hw_ack,
   // stack select, priority level, enable and overflow outputs
   output logic               use_user_stack,
   output logic [PW-1:0]      cpu_prio_level,
   output logic               irq_enable,
   output logic               overflow,
   // avalon-mm slave
   input  wire logic [3:0]    avs_address,
   input  wire logic          avs_read,
   input  wire logic          avs_write,
   input  wire logic [31:0]   avs_writedata,
   input  wire logic [3:0]    avs_byteenable,
   output logic [31:0]        avs_readdata,
   output logic               avs_waitrequest
);
   logic          ovf, next_ovf;
   logic          ien, next_ien;
   logic          stk, next_stk;
   logic [PW-1:0] prio, next_prio;
   logic [PW-1:0] req_prio, next_req_prio;
   logic          req_pend, next_req_pend;
   logic          ack, next_ack;
   logic          done, next_done;
   logic [31:0]   rdata, next_rdata;
   logic          accept;
   logic          wr_now;
   logic          rd_now;
   logic          swi_low;
   logic          st_lane0;
   logic          st_lane1;
   logic          ct_lane0;

   prio_gate #(.PW(PW)) u_gate (
      .req_valid      (hw_req),
      .req_nmi        (hw_req_nmi),
      .req_prio       (hw_req_prio),
      .ien            (ien),
      .cpu_prio_level (prio),
      .accept         (accept)
   );

   // one byte lane of one word, hit by the accepted write
   function automatic logic lane_hit(input logic wr, input logic [3:0] a,
         input logic [3:0] word, input logic lane_en);
      return wr && (a == word) && lane_en;
   endfunction

   function automatic logic [31:0] status_word(input logic o, input logic i,
         input logic u, input logic [PW-1:0] p);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[flag_pkg::POS_OVF] = o;
      w[flag_pkg::POS_IEN] = i;
      w[flag_pkg::POS_STK] = u;
      // reserved bit reads as zero here, which the undefined read allows
      w[flag_pkg::POS_PRIO +: PW] = p;
      return w;
   endfunction

   // one wait cycle per access keeps readdata registered
   assign wr_now   = avs_write & done;
   assign rd_now   = avs_read & ~done;
   // numbers above the low range leave the stack select alone
   assign swi_low  = swi_exec && (swi_num <= 6'(flag_pkg::SWI_LAST_LOW));
   // writes land only in the cycle in which waitrequest is low
   assign st_lane0 = lane_hit(wr_now, avs_address, flag_pkg::ADDR_STATUS,
                              avs_byteenable[0]);
   assign st_lane1 = lane_hit(wr_now, avs_address, flag_pkg::ADDR_STATUS,
                              avs_byteenable[1]);
   assign ct_lane0 = lane_hit(wr_now, avs_address, flag_pkg::ADDR_CTRL,
                              avs_byteenable[0]);

   // flags: software write first, hardware events after it so they win
   always_comb begin
      next_ovf  = ovf;
      next_ien  = ien;
      next_stk  = stk;
      next_prio = prio;
      next_ack  = 1'b0;
      // stack select sits in byte 0 with overflow and enable
      if (st_lane0) begin
         next_ovf = avs_writedata[flag_pkg::POS_OVF];
         next_ien = avs_writedata[flag_pkg::POS_IEN];
         next_stk = avs_writedata[flag_pkg::POS_STK];
      end
      if (st_lane1) begin
         next_prio = avs_writedata[flag_pkg::POS_PRIO +: PW];
      end
      // an operation finishing in the write cycle still sets its flag
      if (alu_update) begin
         next_ovf = alu_overflow;
      end
      // ack is a registered pulse; the source drops its request by then
      if (accept) begin
         next_ack  = 1'b1;
         next_ien  = 1'b0;
         next_stk  = 1'b0;
         next_prio = hw_req_prio;
      end
      // a soft interrupt clears enable whatever its number
      if (swi_exec) begin
         next_ien = 1'b0;
      end
      if (swi_low) begin
         next_stk = 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ovf  <= flag_pkg::OVF_RST;
         ien  <= flag_pkg::IEN_RST;
         stk  <= flag_pkg::STK_RST;
         prio <= PW'(flag_pkg::PRIO_RST);
         ack  <= 1'b0;
      end else begin
         ovf  <= next_ovf;
         ien  <= next_ien;
         stk  <= next_stk;
         prio <= next_prio;
         ack  <= next_ack;
      end
   end

   // scratch control word, read back only, no effect on the gating
   always_comb begin
      next_req_pend = req_pend;
      next_req_prio = req_prio;
      if (ct_lane0) begin
         next_req_pend = avs_writedata[0];
         next_req_prio = avs_writedata[4 +: PW];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         req_pend <= 1'b0;
         req_prio <= '0;
      end else begin
         req_pend <= next_req_pend;
         req_prio <= next_req_prio;
      end
   end

   // read data is captured in the wait cycle and stands until the next read
   // unmapped words read as zero and ignore writes
   always_comb begin
      next_done  = (avs_read | avs_write) & ~done;
      next_rdata = rdata;
      if (rd_now) begin
         unique case (avs_address)
            flag_pkg::ADDR_STATUS: next_rdata = status_word(ovf, ien, stk,
                                                            prio);
            flag_pkg::ADDR_REQ:    next_rdata = {27'h000_0000, accept,
                                                 hw_req, req_pend,
                                                 ack, ien};
            flag_pkg::ADDR_CTRL:   next_rdata = {24'h00_0000, 1'b0,
                                                 req_prio, 3'h0,
                                                 req_pend};
            default:               next_rdata = flag_pkg::UNMAPPED_DATA;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         done  <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         done  <= next_done;
         rdata <= next_rdata;
      end
   end

   assign hw_ack          = ack;
   assign use_user_stack  = stk;
   assign cpu_prio_level  = prio;
   assign irq_enable      = ien;
   assign overflow        = ovf;
   assign avs_readdata    = rdata;
   assign avs_waitrequest = (avs_read | avs_write) & ~done;
endmodule // cpu_flag_interrupt_gating

// [flag_gate_props.sv]
// port checks for the status-word interrupt gating block
`timescale 1ns/1ps
module flag_gate_props #(parameter int PW = 3) (
   // watched ports
   input wire logic          core_clk,
   input wire logic          rst,
   input wire logic          alu_update,
   input wire logic          alu_overflow,
   input wire logic          swi_exec,
   input wire logic [5:0]    swi_num,
   input wire logic          hw_req,
   input wire logic          hw_req_nmi,
   input wire logic [PW-1:0] hw_req_prio,
   input wire logic          hw_ack,
   input wire logic          use_user_stack,
   input wire logic [PW-1:0] cpu_prio_level,
   input wire logic          irq_enable,
   input wire logic          overflow
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_take;
      hw_req && (hw_req_nmi || (irq_enable && hw_req_prio > cpu_prio_level));
   endsequence
   sequence s_masked;
      hw_req && !hw_req_nmi;
   endsequence
   AST_OVF: assert property (
      alu_update |=> overflow == $past(alu_overflow)) else $error("ovf");
   AST_MASK: assert property (
      s_masked ##0 !irq_enable |=> !hw_ack) else $error("masked ack");
   AST_IEN: assert property (
      s_take |=> hw_ack && !irq_enable) else $error("enable kept");
   AST_STK: assert property (
      s_take |=> !use_user_stack) else $error("stack kept");
   AST_SWI: assert property (
      swi_exec && swi_num <= 31 |=> !use_user_stack) else $error("swi");
   AST_LVL: assert property (
      s_take |=> cpu_prio_level == $past(hw_req_prio)) else $error("level");
   AST_PRIO: assert property (
      s_masked ##0 hw_req_prio <= cpu_prio_level |=> !hw_ack)
      else $error("low prio ack");
   AST_ACC: assert property (
      s_masked ##0 irq_enable && hw_req_prio > cpu_prio_level |=> hw_ack)
      else $error("no ack");
endmodule // flag_gate_props
bind cpu_flag_interrupt_gating flag_gate_props #(.PW(PW)) u_flag_gate_props (
   .core_clk       (core_clk),
   .rst            (rst),
   .alu_update     (alu_update),
   .alu_overflow   (alu_overflow),
   .swi_exec       (swi_exec),
   .swi_num        (swi_num),
   .hw_req         (hw_req),
   .hw_req_nmi     (hw_req_nmi),
   .hw_req_prio    (hw_req_prio),
   .hw_ack         (hw_ack),
   .use_user_stack (use_user_stack),
   .cpu_prio_level (cpu_prio_level),
   .irq_enable     (irq_enable),
   .overflow       (overflow)
);

// [req_source.sv]
// request source that withdraws once acknowledged
`timescale 1ns/1ps
module req_source (
   // clock, reset, control
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic want,
   // design side
   input  wire logic hw_ack,
   output logic      hw_req
);
   logic served;
   logic next_served;
   // drops in the ack cycle so it is never judged twice
   assign hw_req = want && !served && !hw_ack;
   always_comb next_served = want && (served || hw_ack);
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) served <= 1'b0;
      else served <= next_served;
   end
endmodule // req_source

// [cpu_flag_interrupt_gating_tb.sv]
// self-checking bench for the status-word gating block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
$display("unexpected %0t %h %h", $time, a, b); end end
module cpu_flag_interrupt_gating_tb;
   logic        core_clk, rst, alu_update, alu_overflow, swi_exec, hw_req;
   logic        hw_req_nmi, hw_ack, use_user_stack, irq_enable, overflow;
   logic        avs_read, avs_write, avs_waitrequest, want;
   logic [5:0]  swi_num;
   logic [2:0]  hw_req_prio, cpu_prio_level;
   logic [3:0]  avs_address, avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, q;
   int          n_errors, total_checks, cycles, acks;
   cpu_flag_interrupt_gating u_cpu_flag_interrupt_gating (
      .core_clk        (core_clk),
      .rst             (rst),
      .alu_update      (alu_update),
      .alu_overflow    (alu_overflow),
      .swi_exec        (swi_exec),
      .swi_num         (swi_num),
      .hw_req          (hw_req),
      .hw_req_nmi      (hw_req_nmi),
      .hw_req_prio     (hw_req_prio),
      .hw_ack          (hw_ack),
      .use_user_stack  (use_user_stack),
      .cpu_prio_level  (cpu_prio_level),
      .irq_enable      (irq_enable),
      .overflow        (overflow),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (avs_byteenable),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest)
   );
   req_source u_req_source (
      .core_clk (core_clk),
      .rst      (rst),
      .want     (want),
      .hw_ack   (hw_ack),
      .hw_req   (hw_req)
   );
   initial begin
      core_clk = 0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic give_verdict();
      if (n_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         give_verdict();
      end
   end
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, wr, !wr};
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      {avs_write, avs_read} <= 2'b00;
   endtask
   task automatic pulse(input logic alu, input logic [5:0] n);
      @(posedge core_clk);
      {alu_update, swi_exec, swi_num} <= {alu, !alu, n};
      @(posedge core_clk);
      {alu_update, swi_exec} <= 2'b00;
      #1;
   endtask
   // counts the acknowledge pulses seen in the four cycles after the request is set
   task automatic req(input logic [2:0] p, input logic w, input logic n);
      @(posedge core_clk);
      {hw_req_prio, want, hw_req_nmi} <= {p, w, n};
      acks = 0;
      repeat (4) begin
         @(posedge core_clk);
         if (hw_ack === 1'b1) acks++;
      end
      #1;
   endtask
   initial begin
      {rst, alu_update, alu_overflow, swi_exec, swi_num, hw_req_nmi} = 11'h400;
      {hw_req_prio, want, avs_read, avs_write, avs_address} = 10'h000;
      {avs_writedata, avs_byteenable} = {32'h0000_0000, 4'hf};
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      bus(0, flag_pkg::ADDR_STATUS, 0);
      `CHK(q, 32'h0000_0000)
      // reserved bit written as 0; level 2, enable and user stack set
      bus(1, flag_pkg::ADDR_STATUS, 32'h0000_20C0);
      bus(0, flag_pkg::ADDR_STATUS, 0);
      `CHK(q, 32'h0000_20C0)
      `CHK(use_user_stack, 1'b1)
      // byte lane 1 alone moves the level and keeps the stack select
      avs_byteenable <= 4'h2;
      bus(1, flag_pkg::ADDR_STATUS, 32'h0000_3000);
      avs_byteenable <= 4'hf;
      bus(0, flag_pkg::ADDR_STATUS, 0);
      `CHK(q, 32'h0000_30C0)
      alu_overflow <= 1'b1;
      pulse(1, 0);
      `CHK(overflow, 1'b1)
      alu_overflow <= 1'b0;
      pulse(1, 0);
      `CHK(overflow, 1'b0)
      req(2, 1, 0);
      `CHK(irq_enable, 1'b1)
      `CHK(acks, 0)
      req(5, 1, 0);
      `CHK(acks, 1)
      `CHK(cpu_prio_level, 3'h5)
      `CHK({irq_enable, use_user_stack}, 2'b00)
      req(7, 0, 0);
      req(7, 1, 0);
      `CHK(acks, 0)
      `CHK(cpu_prio_level, 3'h5)
      req(7, 0, 0);
      // non-maskable request passes the level gate, with enable set
      bus(1, flag_pkg::ADDR_STATUS, 32'h0000_70C0);
      req(3, 1, 1);
      `CHK(acks, 1)
      `CHK({irq_enable, use_user_stack}, 2'b00)
      `CHK(cpu_prio_level, 3'h3)
      req(0, 0, 0);
      bus(1, flag_pkg::ADDR_STATUS, 32'h0000_00C0);
      pulse(0, 6'h20);
      `CHK({irq_enable, use_user_stack}, 2'b01)
      bus(1, flag_pkg::ADDR_STATUS, 32'h0000_00C0);
      pulse(0, 6'h1F);
      `CHK(use_user_stack, 1'b0)
      bus(1, 4'hC, 32'hFFFF_FFFF);
      bus(0, 4'hC, 0);
      `CHK(q, flag_pkg::UNMAPPED_DATA)
      give_verdict();
   end
endmodule // cpu_flag_interrupt_gating_tb
